/* sim/smc_core_setup_chk.sv */
// Port assertions for the startup mode and core setup block
`timescale 1ns/1ns
module smc_core_setup_chk
    import smc_pkg::*;
(
    // Clock, reset and watched inputs
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_nand_ack,
    input wire logic i_host_nand_req,
    input wire logic i_cpu_clk_we,
    input wire logic [1:0] i_cpu_clk_sel,
    input wire logic i_sfr_cycle,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_movx_cycle,
    // Watched outputs
    input wire logic o_nand_rd,
    input wire logic [7:0] o_nand_addr,
    input wire logic o_host_nand_gnt,
    input wire logic [1:0] o_mode,
    input wire logic o_boot_done,
    input wire logic o_usb_attach,
    input wire logic [2:0] o_speed_caps,
    input wire logic o_use_cfg_desc,
    input wire logic o_cpu_run,
    input wire logic o_cpu_clk_en,
    input wire logic [1:0] o_cpu_clk_sel,
    input wire logic o_i2c_enable,
    input wire logic [1:0] o_port_sel,
    input wire logic o_port_hit,
    input wire logic o_sfr_bit_ok
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Steps of a core register cycle and of a flash read, and eight reference cycles without a CPU clock enable
    sequence s_reg_acc;
        i_sfr_cycle && !i_movx_cycle;
    endsequence
    sequence s_rd_wait;
        o_nand_rd && !i_nand_ack;
    endsequence
    sequence s_clk_quiet;
        !o_cpu_clk_en [*8];
    endsequence
    chk_caps_fixed: assert property (
        !$past(i_rst) |-> o_speed_caps == SPEED_CAPS) else $error("bad caps");
    chk_attach_late: assert property (
        o_usb_attach |-> $past(o_boot_done)) else $error("early attach");
    chk_mode_chosen: assert property (
        o_boot_done |-> o_mode inside {SMC_MODE_NORMAL, SMC_MODE_MFG})
        else $error("boot done without mode");
    chk_host_grant: assert property (
        o_host_nand_gnt == ($past(i_host_nand_req)
        && $past(o_mode) == SMC_MODE_NORMAL)) else $error("bad grant");
    chk_desc_source: assert property (
        o_use_cfg_desc == (o_mode == SMC_MODE_NORMAL)) else $error("bad desc");
    chk_i2c_gate: assert property (
        o_i2c_enable |-> $past(o_boot_done)) else $error("early i2c");
    chk_clk_gap: assert property (
        o_cpu_clk_en |-> o_cpu_run ##1 s_clk_quiet) else $error("clk gap");
    chk_clk_write: assert property (
        i_cpu_clk_we && i_cpu_clk_sel != 2'h3 |=>
        o_cpu_clk_sel == $past(i_cpu_clk_sel)) else $error("clk sel lost");
    chk_rd_hold: assert property (
        s_rd_wait |=> o_nand_rd && $stable(o_nand_addr))
        else $error("rd drop");
    chk_port_map: assert property (
        s_reg_acc ##0 i_sfr_addr[3:0] == 4'h0 && i_sfr_addr[7:6] == 2'h2
        |=> o_port_hit && o_port_sel == $past(i_sfr_addr[5:4]))
        else $error("port miss");
    chk_movx_deaf: assert property (
        i_movx_cycle |=> !o_port_hit) else $error("movx hit");
    chk_bit_addr: assert property (
        s_reg_acc |=> o_sfr_bit_ok == ($past(i_sfr_addr[2:0]) == 3'h0))
        else $error("bit flag wrong");
endmodule // smc_core_setup_chk
bind smc_core_setup smc_core_setup_chk u_chk (.*);

/* sim/smc_nand_model.sv */
// Behavioural NAND flash that holds one firmware image
`timescale 1ns/1ns
module smc_nand_model
    import smc_pkg::*;
(
    // Clock and bench controls
    input wire logic i_clk,
    input wire logic i_attached,
    input wire logic i_bad_sig,
    input wire logic [7:0] i_len,
    input wire logic [3:0] i_lat,
    // Byte read handshake
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    output logic o_present,
    output logic o_ack,
    output logic [7:0] o_rdata
);
    logic [3:0] wait_ff;
    logic [7:0] byte_val;
    // Signature low and high, length low and high, then a pattern
    always_comb begin
        case (i_addr)
            8'h00: byte_val = i_bad_sig ? 8'h00 : FW_SIG[7:0];
            8'h01: byte_val = FW_SIG[15:8];
            8'h02: byte_val = i_len;
            8'h03: byte_val = 8'h00;
            default: byte_val = i_addr ^ 8'hC3;
        endcase
    end
    assign o_present = i_attached;
    // Released lines show the inverse, so a late sample is caught
    assign o_rdata = o_ack ? byte_val : ~byte_val;
    // Ack after a set wait, held until the read request drops
    always_ff @(posedge i_clk) begin
        if (!i_attached || !i_rd) begin
            wait_ff <= 4'h0;
            o_ack <= 1'b0;
        end else if (wait_ff < i_lat) begin
            wait_ff <= wait_ff + 4'h1;
        end else begin
            o_ack <= 1'b1;
        end
    end
endmodule // smc_nand_model

/* sim/test_startup_mode_and_core_setup.sv */
// Self-checking bench for startup mode selection and core setup
`timescale 1ns/1ns
module test_startup_mode_and_core_setup;
    import smc_pkg::*;
    localparam int unsigned CHIP_REV = 3;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_host_nand_req = 1'b0;
    logic i_cpu_clk_we = 1'b0, i_i2c_fast = 1'b0, i_sfr_cycle = 1'b0;
    logic i_movx_cycle = 1'b0, i_bus_wide = 1'b0, att = 1'b0, bad = 1'b0;
    logic [1:0] i_cpu_clk_sel = 2'h0, o_mode, o_cpu_clk_sel, o_port_sel;
    logic [3:0] lat = 4'h0;
    logic [7:0] i_sfr_addr = 8'h00, len = 8'h06;
    logic [13:0] i_fetch_addr = 14'h0000;
    logic i_nand_present, i_nand_ack, o_nand_rd, o_host_nand_gnt;
    logic o_boot_done, o_usb_attach, o_use_cfg_desc, o_cpu_run, o_cpu_clk_en;
    logic o_i2c_enable, o_i2c_tick, o_port_hit, o_sfr_bit_ok;
    logic o_bus_lo_port_b, o_bus_hi_port_d;
    logic [7:0] i_nand_rdata, o_nand_addr, o_fetch_data;
    logic [2:0] o_speed_caps;
    logic [15:0] o_vendor_id, o_product_id, o_release_id;
    wire logic [2:0] watch = {o_boot_done, o_i2c_tick, o_cpu_clk_en};
    int err_total = 0;
    int n_checks = 0;
    int p;
    // Reference clock, 8 ns period
    always #4 i_ref_clk = ~i_ref_clk;
    // Design and flash partner
    smc_core_setup #(.CHIP_REV(CHIP_REV)) u_dut (.*);
    smc_nand_model u_nand (.i_clk(i_ref_clk), .i_attached(att),
        .i_bad_sig(bad), .i_len(len), .i_lat(lat), .i_rd(o_nand_rd),
        .i_addr(o_nand_addr), .o_present(i_nand_present),
        .o_ack(i_nand_ack), .o_rdata(i_nand_rdata));
    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Compares a seen value with the expected one
    task automatic check(input string nm, input logic [15:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    // Advances n edges and lets their updates settle
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Bounded wait for the chosen watched output, cycles counted
    task automatic count_to(input int w, output int n);
        n = 0;
        do begin
            step(1);
            n++;
        end while (watch[w] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            err_total++;
            final_report();
        end
    endtask
    // Gap between two pulses of the chosen output
    task automatic period(input int w, input int e);
        count_to(w, p);
        count_to(w, p);
        check(w ? "i2c period" : "cpu period", 16'(p), 16'(e));
    endtask
    // Reset with a chosen flash, then check the mode and identity
    task automatic boot(input logic a, b, input logic [7:0] l, m);
        @(posedge i_ref_clk);
        att <= a;
        bad <= b;
        len <= l;
        i_host_nand_req <= 1'b0;
        i_rst <= 1'b1;
        step(3);
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        count_to(2, p);
        check("mode", 16'(o_mode), 16'(m));
        check("attach early", 16'(o_usb_attach), 16'h0);
        check("desc", 16'(o_use_cfg_desc), 16'(m == 8'h1));
        check("vendor", o_vendor_id, ROM_VENDOR);
        check("product", o_product_id, ROM_PRODUCT);
        check("rel id", o_release_id, {ROM_REL_TOP, 12'(CHIP_REV)});
        check("caps", 16'(o_speed_caps), 16'(SPEED_CAPS));
        @(posedge i_ref_clk);
        i_host_nand_req <= 1'b1;
        step(2);
        check("attach", 16'(o_usb_attach), 16'h1);
        check("i2c on", 16'(o_i2c_enable), 16'h1);
        check("grant", 16'(o_host_nand_gnt), 16'(m == 8'h1));
    endtask
    // Writes the cpu clock control register and measures the result
    task automatic set_clk(input logic [1:0] s, input int e);
        @(posedge i_ref_clk);
        i_cpu_clk_we <= 1'b1;
        i_cpu_clk_sel <= s;
        @(posedge i_ref_clk);
        i_cpu_clk_we <= 1'b0;
        step(1);
        check("clk run", 16'(o_cpu_run), 16'h1);
        check("clk sel", 16'(o_cpu_clk_sel), 16'(s));
        period(0, e);
    endtask
    // One core register cycle, decode seen one edge later
    task automatic special_function_register(input logic [7:0] a, input logic mv, hit);
        @(posedge i_ref_clk);
        i_sfr_cycle <= 1'b1;
        i_movx_cycle <= mv;
        i_sfr_addr <= a;
        @(posedge i_ref_clk);
        i_sfr_cycle <= 1'b0;
        i_movx_cycle <= 1'b0;
        #1;
        check("port hit", 16'(o_port_hit), 16'(hit));
        check("bit ok", 16'(o_sfr_bit_ok), 16'(!mv &&
            (a[3:0] == SFR_BIT_NIB0 || a[3:0] == SFR_BIT_NIB8)));
    endtask
    // Main sequence
    initial begin
        boot(1'b0, 1'b0, 8'h06, 8'(SMC_MODE_MFG));
        $display("test absent flash done");
        boot(1'b1, 1'b1, 8'h06, 8'(SMC_MODE_MFG));
        $display("test bad signature done");
        boot(1'b1, 1'b0, 8'h00, 8'(SMC_MODE_MFG));
        $display("test empty image done");
        lat <= 4'h5;
        boot(1'b1, 1'b0, 8'h06, 8'(SMC_MODE_NORMAL));
        for (int i = 0; i < 6; i++) begin
            @(posedge i_ref_clk);
            i_fetch_addr <= 14'(i);
            step(2);
            check("fetch", 16'(o_fetch_data),
                16'(8'(i + 4) ^ 8'hC3));
        end
        $display("test firmware load done");
        period(0, DIV_12);
        set_clk(CPU_SEL_24, DIV_24);
        set_clk(CPU_SEL_48, DIV_48);
        set_clk(2'h3, DIV_12);
        set_clk(CPU_SEL_12, DIV_12);
        $display("test cpu clock done");
        period(1, I2C_DIV_SLOW);
        @(posedge i_ref_clk);
        i_i2c_fast <= 1'b1;
        period(1, I2C_DIV_FAST);
        $display("test two-wire rate done");
        for (int i = 0; i < 4; i++) begin
            special_function_register(SFR_PORT0 + 8'(i * 16), 1'b0, 1'b1);
            check("port sel", 16'(o_port_sel), 16'(i));
        end
        special_function_register(8'h88, 1'b0, 1'b0);
        special_function_register(8'h81, 1'b0, 1'b0);
        special_function_register(SFR_PORT1, 1'b1, 1'b0);
        $display("test register decode done");
        for (int w = 1; w >= 0; w--) begin
            @(posedge i_ref_clk);
            i_bus_wide <= w[0]; // 8-bit last, as firmware keeps
            step(2);
            check("bus hi", 16'(o_bus_hi_port_d), 16'(w));
            check("bus lo", 16'(o_bus_lo_port_b), 16'h1);
        end
        $display("test bus width done");
        final_report();
    end
endmodule // test_startup_mode_and_core_setup

/* verilog/smc_core_setup.sv */
// Startup mode selection, clock setup and core configuration top
// Notes on behaviour
// - USB link offers full speed 12 Mbps and high speed 480 Mbps.
// - Low speed 1.5 Mbps is never offered.
// - PLL multiplies 24 MHz to 480 MHz; counters divide for the CPU.
// - CPU clock is 12 MHz after reset.
// - CPU clock register write changes divider at run time, no reset.
// - Two-wire controller is master only at 100 or 400 kHz.
// - Two-wire controller disabled until the boot sequencer has selected a mode.
// - At startup probe NAND and check for a valid firmware image.
// - Valid image is loaded into program memory and run: normal mode.
// - No NAND or invalid image falls back to ROM: manufacturing mode.
// - Manufacturing mode enumerates with ROM descriptors and data.
// - Normal mode descriptors come from configuration data memory.
// - Host NAND read and write allowed in normal mode only.
// - ROM identity holds vendor, product, release with revision digits.
// - Four I/O ports sit at the standard port 0 to 3 addresses.
// - I/O ports answer register addressing only, not external moves.
// - Registers at low nibble 0 or 8 are bit-addressable.
// - Parallel data bus is 8 or 16 bits on ports B and D.
`timescale 1ns/1ns
module smc_core_setup
    import smc_pkg::*;
#(
    parameter int unsigned CHIP_REV = 1
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // NAND byte reader, pins from outside
    input wire logic i_nand_present,
    input wire logic i_nand_ack,
    input wire logic [7:0] i_nand_rdata,
    output logic o_nand_rd,
    output logic [7:0] o_nand_addr,
    // Host NAND access request and grant
    input wire logic i_host_nand_req,
    output logic o_host_nand_gnt,
    // CPU clock control register write
    input wire logic i_cpu_clk_we,
    input wire logic [1:0] i_cpu_clk_sel,
    // Two-wire rate select, 1 is 400 kHz
    input wire logic i_i2c_fast,
    // Special-function register access from the core
    input wire logic i_sfr_cycle,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_movx_cycle,
    // Parallel bus width, 1 is 16-bit
    input wire logic i_bus_wide,
    // Program memory fetch port
    input wire logic [13:0] i_fetch_addr,
    output logic [7:0] o_fetch_data,
    // Status and configuration out
    output logic [1:0] o_mode,
    output logic o_boot_done,
    output logic o_usb_attach,
    output logic [2:0] o_speed_caps,
    output logic o_use_cfg_desc,
    output logic o_cpu_run,
    output logic o_cpu_clk_en,
    output logic [1:0] o_cpu_clk_sel,
    output logic o_i2c_enable,
    output logic o_i2c_tick,
    output logic [15:0] o_vendor_id,
    output logic [15:0] o_product_id,
    output logic [15:0] o_release_id,
    output logic [1:0] o_port_sel,
    output logic o_port_hit,
    output logic o_sfr_bit_ok,
    output logic o_bus_lo_port_b,
    output logic o_bus_hi_port_d
);
    typedef enum logic [2:0] {
        SMC_ST_PROBE,
        SMC_ST_HDR,
        SMC_ST_LOAD,
        SMC_ST_DONE
    } smc_boot_t;

    smc_boot_t state_ff;
    smc_mode_t mode_ff;
    logic pres_s1_ff, pres_s2_ff, ack_s1_ff, ack_s2_ff;
    logic [7:0] data_s1_ff, data_s2_ff;
    logic [10:0] tmo_ff;
    logic [1:0] hdr_idx_ff;
    logic [15:0] sig_ff;
    logic [13:0] len_ff;
    logic [13:0] ld_cnt_ff;
    logic rd_ff;
    logic [7:0] addr_ff;
    logic ram_we_ff;
    logic [13:0] ram_waddr_ff;
    logic [7:0] ram_wdata_ff;
    logic boot_done_ff, use_cfg_ff;
    logic [5:0] cpu_div_ff, cpu_cnt_ff;
    logic [1:0] cpu_sel_ff;
    logic cpu_en_ff;
    logic [9:0] i2c_cnt_ff;
    logic i2c_tick_ff, i2c_en_ff;
    logic gnt_ff, attach_ff, port_hit_ff, bit_ok_ff;
    logic [1:0] port_sel_ff;
    logic ack_edge;
    logic [13:0] ram_raddr_unused;

    // Divide ratio for a CPU clock select code
    function automatic logic [5:0] cpu_div(input logic [1:0] sel);
        unique case (sel)
            CPU_SEL_24: cpu_div = DIV_24;
            CPU_SEL_48: cpu_div = DIV_48;
            default: cpu_div = DIV_12;
        endcase
    endfunction

    // Pin inputs pass two flip-flops
    always_ff @(posedge i_ref_clk) begin
        pres_s1_ff <= i_nand_present;
        pres_s2_ff <= pres_s1_ff;
        ack_s1_ff <= i_nand_ack;
        ack_s2_ff <= ack_s1_ff;
        data_s1_ff <= i_nand_rdata;
        data_s2_ff <= data_s1_ff;
    end

    // Read strobe held until the synced ack returns
    assign ack_edge = rd_ff & ack_s2_ff;
    assign ram_raddr_unused = 14'h0000;

    // Boot sequencer: probe, header check, image load
    always_ff @(posedge i_ref_clk) begin
        ram_we_ff <= 1'b0;
        if (i_rst) begin
            state_ff <= SMC_ST_PROBE;
            mode_ff <= SMC_MODE_NONE;
            tmo_ff <= '0;
            hdr_idx_ff <= '0;
            sig_ff <= '0;
            len_ff <= '0;
            ld_cnt_ff <= '0;
            rd_ff <= 1'b0;
            addr_ff <= FW_ADDR_SIG_LO;
            ram_waddr_ff <= '0;
            ram_wdata_ff <= '0;
            boot_done_ff <= 1'b0;
            use_cfg_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                SMC_ST_PROBE: begin
                    // Probe for NAND with a bounded wait
                    if (pres_s2_ff) begin
                        state_ff <= SMC_ST_HDR;
                        rd_ff <= 1'b1;
                        addr_ff <= FW_ADDR_SIG_LO;
                    end else if (tmo_ff == 11'(PROBE_TIMEOUT)) begin
                        mode_ff <= SMC_MODE_MFG;
                        state_ff <= SMC_ST_DONE;
                        boot_done_ff <= 1'b1;
                    end else begin
                        tmo_ff <= tmo_ff + 11'h001;
                    end
                end
                SMC_ST_HDR: begin
                    // Read signature and length bytes
                    if (ack_edge) begin
                        rd_ff <= 1'b0;
                        unique case (hdr_idx_ff)
                            2'h0: sig_ff[7:0] <= data_s2_ff;
                            2'h1: sig_ff[15:8] <= data_s2_ff;
                            2'h2: len_ff[7:0] <= data_s2_ff;
                            2'h3: len_ff[13:8] <= data_s2_ff[5:0];
                        endcase
                        hdr_idx_ff <= hdr_idx_ff + 2'h1;
                        if (hdr_idx_ff == 2'h3) begin
                            state_ff <= SMC_ST_LOAD;
                        end
                    end else if (!rd_ff && !ack_s2_ff) begin
                        rd_ff <= 1'b1;
                        addr_ff <= {6'h00, hdr_idx_ff};
                    end
                end
                SMC_ST_LOAD: begin
                    // Bad header means ROM fallback
                    if (sig_ff != FW_SIG || len_ff == 14'h0000 ||
                        len_ff > FW_MAX_BYTES) begin
                        mode_ff <= SMC_MODE_MFG;
                        state_ff <= SMC_ST_DONE;
                        boot_done_ff <= 1'b1;
                    end else if (ld_cnt_ff == len_ff) begin
                        mode_ff <= SMC_MODE_NORMAL;
                        use_cfg_ff <= 1'b1;
                        state_ff <= SMC_ST_DONE;
                        boot_done_ff <= 1'b1;
                    end else if (ack_edge) begin
                        // Copy image byte into program memory
                        rd_ff <= 1'b0;
                        ram_we_ff <= 1'b1;
                        ram_waddr_ff <= ld_cnt_ff;
                        ram_wdata_ff <= data_s2_ff;
                        ld_cnt_ff <= ld_cnt_ff + 14'h0001;
                    end else if (!rd_ff && !ack_s2_ff) begin
                        rd_ff <= 1'b1;
                        addr_ff <= 8'(ld_cnt_ff + FW_DATA_BASE);
                    end
                end
                SMC_ST_DONE: begin
                    rd_ff <= 1'b0;
                end
                default: state_ff <= SMC_ST_PROBE;
            endcase
        end
    end

    // Program memory for the loaded image
    smc_prog_ram u_ram (
        .i_ref_clk(i_ref_clk),
        .i_we(ram_we_ff),
        .i_waddr(ram_waddr_ff),
        .i_wdata(ram_wdata_ff),
        .i_raddr(boot_done_ff ? i_fetch_addr : ram_raddr_unused),
        .o_rdata(o_fetch_data)
    );

    // CPU clock divider from the PLL-rate model
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cpu_sel_ff <= CPU_SEL_RST;
            cpu_div_ff <= DIV_12;
        end else if (i_cpu_clk_we) begin
            cpu_sel_ff <= i_cpu_clk_sel;
            cpu_div_ff <= cpu_div(i_cpu_clk_sel);
        end
    end

    // Enable pulse per divided CPU cycle, divider reloads live
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cpu_cnt_ff <= '0;
            cpu_en_ff <= 1'b0;
        end else if (cpu_cnt_ff >= cpu_div_ff - 6'h01) begin
            cpu_cnt_ff <= '0;
            cpu_en_ff <= boot_done_ff;
        end else begin
            cpu_cnt_ff <= cpu_cnt_ff + 6'h01;
            cpu_en_ff <= 1'b0;
        end
    end

    // Two-wire master gate and bit-rate tick
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            i2c_en_ff <= 1'b0;
            i2c_cnt_ff <= '0;
            i2c_tick_ff <= 1'b0;
        end else begin
            i2c_en_ff <= boot_done_ff;
            if (!i2c_en_ff) begin
                i2c_cnt_ff <= '0;
                i2c_tick_ff <= 1'b0;
            end else if (i2c_cnt_ff >= (i_i2c_fast ? I2C_DIV_FAST :
                         I2C_DIV_SLOW) - 10'h001) begin
                i2c_cnt_ff <= '0;
                i2c_tick_ff <= 1'b1;
            end else begin
                i2c_cnt_ff <= i2c_cnt_ff + 10'h001;
                i2c_tick_ff <= 1'b0;
            end
        end
    end

    // USB attach and host NAND grant after mode selection
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            attach_ff <= 1'b0;
            gnt_ff <= 1'b0;
        end else begin
            attach_ff <= boot_done_ff;
            gnt_ff <= i_host_nand_req &&
                      mode_ff == SMC_MODE_NORMAL;
        end
    end

    // Port register decode, register addressing only
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            port_hit_ff <= 1'b0;
            port_sel_ff <= '0;
            bit_ok_ff <= 1'b0;
        end else begin
            port_hit_ff <= 1'b0;
            bit_ok_ff <= 1'b0;
            if (i_sfr_cycle && !i_movx_cycle) begin
                bit_ok_ff <= i_sfr_addr[3:0] == SFR_BIT_NIB0 ||
                             i_sfr_addr[3:0] == SFR_BIT_NIB8;
                unique case (i_sfr_addr)
                    SFR_PORT0: begin port_hit_ff <= 1'b1;
                        port_sel_ff <= 2'h0; end
                    SFR_PORT1: begin port_hit_ff <= 1'b1;
                        port_sel_ff <= 2'h1; end
                    SFR_PORT2: begin port_hit_ff <= 1'b1;
                        port_sel_ff <= 2'h2; end
                    SFR_PORT3: begin port_hit_ff <= 1'b1;
                        port_sel_ff <= 2'h3; end
                    default: port_hit_ff <= 1'b0;
                endcase
            end
        end
    end

    // Registered configuration outputs
    logic bus_lo_ff, bus_hi_ff;
    logic [15:0] vid_ff, pid_ff, rel_ff;
    logic [2:0] caps_ff;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            bus_lo_ff <= 1'b0;
            bus_hi_ff <= 1'b0;
            vid_ff <= '0;
            pid_ff <= '0;
            rel_ff <= '0;
            caps_ff <= '0;
        end else begin
            bus_lo_ff <= 1'b1;
            bus_hi_ff <= i_bus_wide;
            caps_ff <= SPEED_CAPS;
            // ROM identity in every mode
            vid_ff <= ROM_VENDOR;
            pid_ff <= ROM_PRODUCT;
            rel_ff <= {ROM_REL_TOP, 12'(CHIP_REV)};
        end
    end

    assign o_nand_rd = rd_ff;
    assign o_nand_addr = addr_ff;
    assign o_host_nand_gnt = gnt_ff;
    assign o_mode = mode_ff;
    assign o_boot_done = boot_done_ff;
    assign o_usb_attach = attach_ff;
    assign o_speed_caps = caps_ff;
    assign o_use_cfg_desc = use_cfg_ff;
    assign o_cpu_run = boot_done_ff;
    assign o_cpu_clk_en = cpu_en_ff;
    assign o_cpu_clk_sel = cpu_sel_ff;
    assign o_i2c_enable = i2c_en_ff;
    assign o_i2c_tick = i2c_tick_ff;
    assign o_vendor_id = vid_ff;
    assign o_product_id = pid_ff;
    assign o_release_id = rel_ff;
    assign o_port_sel = port_sel_ff;
    assign o_port_hit = port_hit_ff;
    assign o_sfr_bit_ok = bit_ok_ff;
    assign o_bus_lo_port_b = bus_lo_ff;
    assign o_bus_hi_port_d = bus_hi_ff;
endmodule // smc_core_setup

/* verilog/smc_pkg.sv */
// Constants and types for the startup mode and core setup block
package smc_pkg;
    // Core reference clock of this logic
    localparam int unsigned REF_CLK_HZ = 125000000;
    // Documented clock figures
    localparam int unsigned XTAL_HZ = 24000000;
    localparam int unsigned PLL_HZ = 480000000;
    localparam int unsigned CPU_DEFAULT_HZ = 12000000;
    localparam int unsigned FS_BPS = 12000000;
    localparam int unsigned HS_BPS = 480000000;
    localparam int unsigned LS_BPS = 1500000;
    localparam int unsigned I2C_SLOW_HZ = 100000;
    localparam int unsigned I2C_FAST_HZ = 400000;
    // PLL multiply factor
    localparam int unsigned PLL_MULT = PLL_HZ / XTAL_HZ;
    // CPU clock select codes, divide ratio from the PLL output
    localparam logic [1:0] CPU_SEL_12 = 2'h0;
    localparam logic [1:0] CPU_SEL_24 = 2'h1;
    localparam logic [1:0] CPU_SEL_48 = 2'h2;
    localparam logic [1:0] CPU_SEL_RST = CPU_SEL_12;
    localparam logic [5:0] DIV_12 = 6'(PLL_HZ / CPU_DEFAULT_HZ);
    localparam logic [5:0] DIV_24 = 6'(PLL_HZ / (2 * CPU_DEFAULT_HZ));
    localparam logic [5:0] DIV_48 = 6'(PLL_HZ / (4 * CPU_DEFAULT_HZ));
    // Two-wire bit-rate enable period in reference cycles (half bit)
    localparam logic [9:0] I2C_DIV_SLOW = 10'(REF_CLK_HZ / (2 * I2C_SLOW_HZ));
    localparam logic [9:0] I2C_DIV_FAST = 10'(REF_CLK_HZ / (2 * I2C_FAST_HZ));
    // Speed capability bits: bit0 full speed, bit1 high speed, bit2 low
    localparam logic [2:0] SPEED_CAPS = 3'h3;
    // Firmware image header signature and size limits
    localparam logic [15:0] FW_SIG = 16'hA55A;
    localparam logic [13:0] FW_MAX_BYTES = 14'h3C00;
    localparam logic [7:0] FW_ADDR_SIG_LO = 8'h00;
    localparam logic [7:0] FW_ADDR_SIG_HI = 8'h01;
    localparam logic [7:0] FW_ADDR_LEN_LO = 8'h02;
    localparam logic [7:0] FW_ADDR_LEN_HI = 8'h03;
    localparam logic [13:0] FW_DATA_BASE = 14'h0004;
    // NAND probe timeout in reference cycles
    localparam int unsigned PROBE_TIMEOUT = 1024;
    // Arbitrary neutral identity values
    localparam logic [15:0] ROM_VENDOR = 16'h1234; // Arbitrary value
    localparam logic [15:0] ROM_PRODUCT = 16'h5678; // Arbitrary value
    localparam logic [3:0] ROM_REL_TOP = 4'h1; // Arbitrary value
    // Special-function register map of the four I/O ports
    localparam logic [7:0] SFR_PORT0 = 8'h80;
    localparam logic [7:0] SFR_PORT1 = 8'h90;
    localparam logic [7:0] SFR_PORT2 = 8'hA0;
    localparam logic [7:0] SFR_PORT3 = 8'hB0;
    localparam logic [3:0] SFR_BIT_NIB0 = 4'h0;
    localparam logic [3:0] SFR_BIT_NIB8 = 4'h8;
    // Operating modes
    typedef enum logic [1:0] {
        SMC_MODE_NONE,
        SMC_MODE_NORMAL,
        SMC_MODE_MFG
    } smc_mode_t;
endpackage

/* verilog/smc_prog_ram.sv */
// Program memory that holds the firmware image loaded from NAND
`timescale 1ns/1ns
module smc_prog_ram (
    // Clock
    input wire logic i_ref_clk,
    // Write port
    input wire logic i_we,
    input wire logic [13:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // Read port
    input wire logic [13:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:15359];
    logic [7:0] rdata_ff;

    // Registered write and read
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        rdata_ff <= mem[i_raddr];
    end

    assign o_rdata = rdata_ff;
endmodule // smc_prog_ram
